// ### blanking_and_burst_level_select.v
// Function
// - 20 ms blanking before burst or restart
// - overload blanking extendable by external capacitor
// - after 20 ms hold gate, start charging
// - high threshold: count, stop charge, discharge
// - low threshold: stop discharge, recharge
// - after 256 cycles completion held high
// - both gate inputs: 30 us, then restart
// - four burst levels, one disables burst
// - detect once, first 1 ms after turn-on
// - protection before start postpones detection
// - feedback high: set flop, discharge, count
// - feedback low: clear flop, recharge, repeat
// - window end: latch level from count
// - three thresholds plus never-burst setting
// - burst timer: 20 ms below threshold enters
// - feedback above exit level leaves burst
`include "blanking_consts.vh"
`default_nettype none

module blanking_and_burst_level_select #(
    parameter [14:0] BLANK_TICKS  = `BLANK_TIME_MS * `US_PER_MS / `TICK_US,
    parameter [9:0]  DETECT_TICKS = `DETECT_TIME_MS * `US_PER_MS / `TICK_US,
    parameter [5:0]  SPIKE_TICKS  = `SPIKE_TIME_US / `TICK_US,
    parameter [7:0]  LEVEL1_MIN   = 8'h04,
    parameter [7:0]  LEVEL2_MIN   = 8'h20,
    parameter [7:0]  LEVEL3_MIN   = 8'h80
) (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // analog front-end decisions (asynchronous)
    input  wire        vcc_on_cmp,
    input  wire        protect_active,
    input  wire        overload_cmp,
    input  wire        extend_high_comparator,
    input  wire        extend_low_comparator,
    input  wire        feedback_high_cmp,
    input  wire        feedback_low_cmp,
    input  wire        burst_monitor_comparator,
    input  wire        feedback_exit_cmp,
    // controls to the analog side
    output reg         extend_charge_switch,
    output reg         extend_discharge_switch,
    output reg         detect_flip_flop,
    output reg         detect_discharge_switch,
    output reg  [1:0]  burst_entry_threshold,
    output reg         level_valid,
    output reg         burst_active,
    output reg         auto_restart,
    output reg         irq
);
    // ********************************
    // synchronisers and time base
    // ********************************
    wire       vcc_on_s, protect_s, overload_s, ext_high_s, ext_low_s;
    wire       fb_high_s, fb_low_s, fb_below_s, fb_exit_s;
    wire       tick;
    reg  [`DIV_W-1:0] div_q;

    sync2 #(.W(9)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({vcc_on_cmp, protect_active, overload_cmp, extend_high_comparator,
                    extend_low_comparator, feedback_high_cmp, feedback_low_cmp,
                    burst_monitor_comparator, feedback_exit_cmp}),
        .sync_out ({vcc_on_s, protect_s, overload_s, ext_high_s, ext_low_s,
                    fb_high_s, fb_low_s, fb_below_s, fb_exit_s})
    );

    tick_divider #(.W(`DIV_W)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .reload  (div_q),
        .tick    (tick)
    );

    reg ctrl_extend_q;

    // ********************************
    // protection blanking: basic, extension, spike, restart
    // ********************************
    localparam B_IDLE  = 3'd0;
    localparam B_BASIC = 3'd1;
    localparam B_CHG   = 3'd2;
    localparam B_DIS   = 3'd3;
    localparam B_SPIKE = 3'd4;
    localparam B_RST   = 3'd5;

    reg [2:0]            bst_q;
    reg [14:0]           bt_q;
    reg [`EXT_CNT_W-1:0] ext_cnt_q;
    reg                  ext_done_q;

    // overload dropping at any point before restart abandons the blanking
    always @(posedge aclk) begin
        if (!aresetn) begin
            bst_q                   <= B_IDLE;
            bt_q                    <= 15'h0000;
            ext_cnt_q               <= {`EXT_CNT_W{1'b0}};
            ext_done_q              <= 1'b0;
            extend_charge_switch    <= 1'b0;
            extend_discharge_switch <= 1'b0;
            auto_restart            <= 1'b0;
        end else begin
            case (bst_q)
                B_IDLE: begin
                    bt_q                    <= 15'h0000;
                    ext_cnt_q               <= {`EXT_CNT_W{1'b0}};
                    ext_done_q              <= 1'b0;
                    extend_charge_switch    <= 1'b0;
                    extend_discharge_switch <= 1'b0;
                    if (overload_s)
                        bst_q <= B_BASIC;
                end
                B_BASIC: begin
                    if (!overload_s) begin
                        bst_q <= B_IDLE;
                    end else if (tick) begin
                        if (bt_q == BLANK_TICKS - 15'h0001) begin
                            bt_q <= 15'h0000;
                            if (ctrl_extend_q) begin
                                bst_q                <= B_CHG;
                                extend_charge_switch <= 1'b1;
                            end else begin
                                bst_q <= B_SPIKE;
                            end
                        end else begin
                            bt_q <= bt_q + 15'h0001;
                        end
                    end
                end
                B_CHG: begin
                    if (!overload_s) begin
                        bst_q <= B_IDLE;
                    end else if (ext_high_s) begin
                        ext_cnt_q               <= ext_cnt_q + {{(`EXT_CNT_W-1){1'b0}}, 1'b1};
                        extend_charge_switch    <= 1'b0;
                        extend_discharge_switch <= 1'b1;
                        if (ext_cnt_q == `EXT_COUNT_END - {{(`EXT_CNT_W-1){1'b0}}, 1'b1}) begin
                            ext_done_q <= 1'b1;
                            bst_q      <= B_SPIKE;
                        end else begin
                            bst_q <= B_DIS;
                        end
                    end
                end
                B_DIS: begin
                    if (!overload_s) begin
                        bst_q <= B_IDLE;
                    end else if (ext_low_s) begin
                        extend_discharge_switch <= 1'b0;
                        extend_charge_switch    <= 1'b1;
                        bst_q                   <= B_CHG;
                    end
                end
                B_SPIKE: begin
                    // both gate inputs high here: basic done and extension done or unused
                    if (ext_low_s)
                        extend_discharge_switch <= 1'b0;
                    if (!overload_s) begin
                        bst_q <= B_IDLE;
                    end else if (tick) begin
                        if (bt_q[5:0] == SPIKE_TICKS - 6'h01) begin
                            auto_restart <= 1'b1;
                            bst_q        <= B_RST;
                        end else begin
                            bt_q <= bt_q + 15'h0001;
                        end
                    end
                end
                B_RST: begin
                    // restart lasts until the supply drops out
                    if (ext_low_s)
                        extend_discharge_switch <= 1'b0;
                    if (!vcc_on_s) begin
                        auto_restart <= 1'b0;
                        bst_q        <= B_IDLE;
                    end
                end
                default: begin
                    bst_q <= B_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // one-time burst level detection
    // ********************************
    localparam D_WAIT = 2'd0;
    localparam D_RUN  = 2'd1;
    localparam D_DONE = 2'd2;

    reg [1:0] dst_q;
    reg [9:0] dt_q;
    reg [7:0] dcnt_q;

    // fewer charge cycles means a larger capacitor and a lower entry threshold code
    function [1:0] level_of;
        input [7:0] cnt;
        begin
            if (cnt < LEVEL1_MIN)
                level_of = 2'h0;
            else if (cnt < LEVEL2_MIN)
                level_of = 2'h1;
            else if (cnt < LEVEL3_MIN)
                level_of = 2'h2;
            else
                level_of = `LEVEL_NEVER;
        end
    endfunction

    // done state is left only by reset, so auto restarts never re-detect
    always @(posedge aclk) begin
        if (!aresetn) begin
            dst_q                   <= D_WAIT;
            dt_q                    <= 10'h000;
            dcnt_q                  <= 8'h00;
            detect_flip_flop        <= 1'b0;
            detect_discharge_switch <= 1'b0;
            burst_entry_threshold   <= `LEVEL_NEVER;
            level_valid             <= 1'b0;
        end else begin
            case (dst_q)
                D_WAIT: begin
                    dt_q   <= 10'h000;
                    dcnt_q <= 8'h00;
                    if (vcc_on_s && !protect_s)
                        dst_q <= D_RUN;
                end
                D_RUN: begin
                    if (!vcc_on_s) begin
                        dst_q                   <= D_WAIT;
                        detect_flip_flop        <= 1'b0;
                        detect_discharge_switch <= 1'b0;
                    end else if (tick && dt_q == DETECT_TICKS - 10'h001) begin
                        burst_entry_threshold   <= level_of(dcnt_q);
                        level_valid             <= 1'b1;
                        detect_flip_flop        <= 1'b0;
                        detect_discharge_switch <= 1'b0;
                        dst_q                   <= D_DONE;
                    end else begin
                        if (tick)
                            dt_q <= dt_q + 10'h001;
                        if (fb_high_s && !detect_flip_flop) begin
                            detect_flip_flop        <= 1'b1;
                            detect_discharge_switch <= 1'b1;
                            if (dcnt_q != 8'hff)
                                dcnt_q <= dcnt_q + 8'h01;
                        end else if (fb_low_s && detect_flip_flop) begin
                            detect_flip_flop        <= 1'b0;
                            detect_discharge_switch <= 1'b0;
                        end
                    end
                end
                D_DONE: begin
                    dst_q <= D_DONE;
                end
                default: begin
                    dst_q <= D_WAIT;
                end
            endcase
        end
    end

    // ********************************
    // active burst entry and exit
    // ********************************
    reg [14:0] bb_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            bb_q         <= 15'h0000;
            burst_active <= 1'b0;
        end else if (!level_valid || burst_entry_threshold == `LEVEL_NEVER || auto_restart) begin
            bb_q         <= 15'h0000;
            burst_active <= 1'b0;
        end else if (burst_active) begin
            bb_q <= 15'h0000;
            if (fb_exit_s)
                burst_active <= 1'b0;
        end else if (!fb_below_s) begin
            bb_q <= 15'h0000;
        end else if (tick) begin
            if (bb_q == BLANK_TICKS - 15'h0001) begin
                bb_q         <= 15'h0000;
                burst_active <= 1'b1;
            end else begin
                bb_q <= bb_q + 15'h0001;
            end
        end
    end

    // ********************************
    // register slave and interrupt
    // ********************************
    localparam [`DIV_W-1:0] DIV_RST = `CLK_MHZ * `TICK_US;  // one tick per microsecond
    reg [7:0]        waddr_q;
    reg [31:0]       wdata_q;
    reg [3:0]        wstrb_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    reg [2:0]        prev_q;
    reg [`IRQ_W-1:0] irq_clr;
    reg [`IRQ_W-1:0] irq_stat_d;

    wire aw_held = ~s_axi_awready;
    wire w_held  = ~s_axi_wready;
    wire do_wr   = aw_held & w_held & ~s_axi_bvalid;
    wire do_rd   = s_axi_arvalid & s_axi_arready;

    wire [`IRQ_W-1:0] irq_ev;
    assign irq_ev[`IRQ_RESTART]   = auto_restart & ~prev_q[0];
    assign irq_ev[`IRQ_BURST_IN]  = burst_active & ~prev_q[1];
    assign irq_ev[`IRQ_BURST_OUT] = ~burst_active & prev_q[1];
    assign irq_ev[`IRQ_LEVEL]     = level_valid & ~prev_q[2];

    // a new event wins over the read that clears its bit
    always @* begin
        irq_clr    = (do_rd && s_axi_araddr == `ADDR_IRQ_STAT) ? irq_stat_q : {`IRQ_W{1'b0}};
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
    end

    // one write and one read in flight; address and data taken in any order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            waddr_q       <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            ctrl_extend_q <= `CTRL_RST;
            irq_mask_q    <= `IRQ_MASK_RST;
            div_q         <= DIV_RST;
            irq_stat_q    <= {`IRQ_W{1'b0}};
            prev_q        <= 3'h0;
            irq           <= 1'b0;
        end else begin
            prev_q     <= {level_valid, burst_active, auto_restart};
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_d & irq_mask_q);
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (waddr_q)
                    `ADDR_CTRL:     if (wstrb_q[0]) ctrl_extend_q <= wdata_q[`CTRL_EXTEND_BIT];
                    `ADDR_IRQ_MASK: if (wstrb_q[0]) irq_mask_q <= wdata_q[`IRQ_W-1:0];
                    `ADDR_DIV: begin
                        if (wstrb_q[0]) div_q[7:0] <= wdata_q[7:0];
                        if (wstrb_q[1]) div_q[15:8] <= wdata_q[15:8];
                    end
                    `ADDR_STATUS, `ADDR_IRQ_STAT, `ADDR_DET_COUNT: s_axi_bresp <= `RESP_OKAY;
                    default:        s_axi_bresp   <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (do_rd) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_CTRL:      s_axi_rdata <= {31'h0, ctrl_extend_q};
                    `ADDR_STATUS:    s_axi_rdata <= {23'h0, ext_done_q, bst_q, auto_restart,
                                                     burst_active, level_valid, burst_entry_threshold};
                    `ADDR_IRQ_STAT:  s_axi_rdata <= {28'h0, irq_stat_q};
                    `ADDR_IRQ_MASK:  s_axi_rdata <= {28'h0, irq_mask_q};
                    `ADDR_DIV:       s_axi_rdata <= {16'h0, div_q};
                    `ADDR_DET_COUNT: s_axi_rdata <= {23'h0, ext_cnt_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // blanking_and_burst_level_select

`default_nettype wire

// ### blanking_and_burst_level_select_asserts.sv
`default_nettype none
// ********************************
// port checker
// ********************************
module blanking_asserts #(
    parameter int BLANK_TICKS = 20,
    parameter int SPIKE_TICKS = 3
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       overload_cmp,
    input wire logic       vcc_on_cmp,
    input wire logic       burst_monitor_comparator,
    input wire logic       feedback_exit_cmp,
    input wire logic       extend_charge_switch,
    input wire logic       extend_discharge_switch,
    input wire logic       detect_flip_flop,
    input wire logic       detect_discharge_switch,
    input wire logic [1:0] burst_entry_threshold,
    input wire logic       level_valid,
    input wire logic       burst_active,
    input wire logic       auto_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    int ovl_q;
    int mon_q;
    // raw run lengths; ticks are never faster than cycles, so these bound the timers
    always @(posedge aclk) begin
        ovl_q <= (!aresetn || !overload_cmp) ? 0 : ovl_q + 1;
        mon_q <= (!aresetn || !burst_monitor_comparator) ? 0 : mon_q + 1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence exit_held;
        feedback_exit_cmp [*4];
    endsequence
    sequence supply_held;
        vcc_on_cmp [*3];
    endsequence
    a_switch_excl: assert property (!(extend_charge_switch && extend_discharge_switch))
        else $error("both blanking cap switches closed");
    a_detect_pair: assert property (detect_flip_flop == detect_discharge_switch)
        else $error("detect flop and discharge switch differ");
    a_detect_once: assert property ($rose(detect_flip_flop) |-> !level_valid)
        else $error("detection ran after level latched");
    a_level_held: assert property (level_valid |=> level_valid && $stable(burst_entry_threshold))
        else $error("latched level changed");
    a_never_burst: assert property (burst_entry_threshold == 2'h3 |-> !burst_active)
        else $error("burst with never setting");
    a_blank_first: assert property ($rose(auto_restart) |-> ovl_q >= BLANK_TICKS + SPIKE_TICKS)
        else $error("restart before blanking");
    a_charge_late: assert property ($rose(extend_charge_switch) |-> ovl_q >= BLANK_TICKS)
        else $error("charge before basic blanking");
    a_burst_entry: assert property ($rose(burst_active) |-> mon_q >= BLANK_TICKS && level_valid)
        else $error("burst entered early");
    a_burst_exit: assert property (exit_held |=> !burst_active)
        else $error("burst not left");
    a_restart_held: assert property (supply_held ##0 auto_restart |=> auto_restart)
        else $error("restart dropped with supply up");
endmodule // blanking_asserts
`default_nettype wire

// ### blanking_and_burst_level_select_pad.v
`default_nettype none
`default_nettype wire

// ### blanking_consts.vh
`ifndef BLANKING_CONSTS_VH
`define BLANKING_CONSTS_VH

// ********************************
// clock and time base
// ********************************
`define CLK_MHZ          100
`define TICK_US          1
`define BLANK_TIME_MS    20
`define DETECT_TIME_MS   1
`define SPIKE_TIME_US    30
`define US_PER_MS        1000

// ********************************
// register offsets (byte addresses)
// ********************************
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_IRQ_STAT    8'h08
`define ADDR_IRQ_MASK    8'h0c
`define ADDR_DIV         8'h10
`define ADDR_DET_COUNT   8'h14

// ********************************
// fields and reset values
// ********************************
`define CTRL_EXTEND_BIT  0
`define CTRL_RST         1'b0
`define DIV_W            16
`define IRQ_W            4
`define IRQ_RESTART      0
`define IRQ_BURST_IN     1
`define IRQ_BURST_OUT    2
`define IRQ_LEVEL        3
`define IRQ_MASK_RST     4'h0
`define EXT_CNT_W        9
`define EXT_COUNT_END    9'h100
`define LEVEL_NEVER      2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ### cap_model.sv
`default_nettype none
// ********************************
// timing capacitor seen through two comparators
// ********************************
module cap_model #(
    parameter int STEP = 9,
    parameter int LO   = 9
) (
    input  wire logic clk,
    input  wire logic chg,
    input  wire logic dis,
    output logic      hi,
    output logic      lo
);
    timeunit 1ns;
    timeprecision 1ps;
    int v = 0;
    // voltage in tenths of a volt; an open cap holds its charge, no kinder than the real part
    always @(posedge clk) begin
        if (chg)
            v <= (v + STEP > 45) ? 45 : v + STEP;
        else if (dis)
            v <= (v < STEP) ? 0 : v - STEP;
    end
    assign hi = v >= 45; // 4.5V trip
    assign lo = v <= LO;
endmodule // cap_model
`default_nettype wire

// ### sync2.v
`default_nettype none

// ********************************
// two-stage synchroniser for asynchronous comparator levels
// ********************************
module sync2 #(
    parameter W = 1
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // sync2

`default_nettype wire

// ### tb_blanking_and_burst_level_select.sv
`default_nettype none
module tb_blanking_and_burst_level_select;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIM = 20000;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, vcc_on_cmp = 0, protect_active = 1;
    logic overload_cmp = 0, burst_monitor_comparator = 0, feedback_exit_cmp = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, burst_entry_threshold, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic extend_high_comparator, extend_low_comparator, feedback_high_cmp, feedback_low_cmp;
    logic extend_charge_switch, extend_discharge_switch, detect_flip_flop, detect_discharge_switch;
    logic level_valid, burst_active, auto_restart;
    int bad_count = 0, n_compared = 0, n;
    always #5 aclk = ~aclk;
    // short counts keep the run brief; DIV is set to one cycle per tick below
    blanking_and_burst_level_select #(.BLANK_TICKS(15'd20), .DETECT_TICKS(10'd200), .SPIKE_TICKS(6'd3))
        i_blanking_and_burst_level_select (.*);
    cap_model i_cap_model (.clk(aclk), .chg(extend_charge_switch), .dis(extend_discharge_switch),
        .hi(extend_high_comparator), .lo(extend_low_comparator));
    cap_model #(.STEP(45), .LO(5)) i_cap_model_fb (.clk(aclk), .chg(!detect_discharge_switch),
        .dis(detect_discharge_switch), .hi(feedback_high_cmp), .lo(feedback_low_cmp));
    task complete_run;
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task hang(input int k);
        if (k >= LIM) begin
            bad_count++;
            complete_run;
        end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ********************************
    // axi4-lite master: hold each channel until its own ready
    // ********************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (k = 0; k < LIM; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        hang(k);
        chk(s_axi_bresp, 2'h0);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (k = 0; k < LIM; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        hang(k);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    initial begin
        cyc(2);
        aresetn <= 1;
        rc(8'h10, 32'h64);
        rc(8'h0c, 32'h0);
        rd(8'h20, d, r);
        chk(r, 2'h2);
        wr(8'h10, 32'h1);
        vcc_on_cmp <= 1;
        cyc(300);
        chk(level_valid, 1'h0);
        protect_active <= 0;
        for (n = 0; n < LIM && level_valid !== 1; n++) cyc(1);
        hang(n);
        chk(burst_entry_threshold, 2'h1);
        chk(irq, 1'h0);
        wr(8'h0c, 32'h8);
        cyc(2);
        chk(irq, 1'h1);
        rc(8'h08, 32'h8);
        cyc(3);
        chk(irq, 1'h0);
        // a short dip below the entry level must not start burst
        burst_monitor_comparator <= 1;
        cyc(10);
        burst_monitor_comparator <= 0;
        cyc(5);
        chk(burst_active, 1'h0);
        burst_monitor_comparator <= 1;
        cyc(40);
        chk(burst_active, 1'h1);
        feedback_exit_cmp <= 1;
        burst_monitor_comparator <= 0;
        cyc(6);
        chk(burst_active, 1'h0);
        feedback_exit_cmp <= 0;
        rc(8'h08, 32'h6);
        overload_cmp <= 1;
        cyc(10);
        overload_cmp <= 0;
        cyc(5);
        chk(auto_restart, 1'h0);
        overload_cmp <= 1;
        for (n = 0; n < LIM && auto_restart !== 1; n++) cyc(1);
        hang(n);
        chk(n >= 23, 1'h1);
        rc(8'h04, 32'hb5);
        overload_cmp <= 0;
        vcc_on_cmp <= 0;
        cyc(5);
        chk(auto_restart, 1'h0);
        vcc_on_cmp <= 1;
        cyc(300);
        chk(burst_entry_threshold, 2'h1);
        wr(8'h00, 32'h1);
        overload_cmp <= 1;
        for (n = 0; n < LIM && auto_restart !== 1; n++) cyc(1);
        hang(n);
        chk(n > 1024, 1'h1);
        rc(8'h14, 32'h100);
        complete_run;
    end
endmodule // tb_blanking_and_burst_level_select
bind blanking_and_burst_level_select blanking_asserts #(.BLANK_TICKS(BLANK_TICKS), .SPIKE_TICKS(SPIKE_TICKS))
    i_blanking_asserts (.*);
`default_nettype wire

// ### tick_divider.v
`default_nettype none

// ********************************
// time-base divider: one-cycle tick every reload cycles
// ********************************
module tick_divider #(
    parameter W = 16
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] reload,
    output reg          tick
);
    reg [W-1:0] cnt_q;

    // a reload of zero behaves like one, so the tick never stops
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= {W{1'b0}};
            tick  <= 1'b0;
        end else if ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1} >= {1'b0, reload}) begin
            cnt_q <= {W{1'b0}};
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule // tick_divider

`default_nettype wire
